// [design/tieoff_regs.sv]
// output tie-off override, mute status and serial mode key register bank
`default_nettype none
module tieoff_regs (
    // clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       NRST,
    // register port
    input  wire logic [7:0] ADDR,
    input  wire logic [8:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [8:0] RDATA,
    // mute status from dac path
    input  wire logic       ANA_MUTE_IN,
    input  wire logic       LEFT_ZERO_IN,
    input  wire logic       RIGHT_ZERO_IN,
    // automatic switch requests
    input  wire logic [7:0] AUTO_SWITCH,
    // buffer enables
    input  wire logic       BOOST_BUF_EN,
    input  wire logic       UNITY_BUF_EN,
    // switch controls
    output logic            BOOST_BYPASS_CLOSE,
    output logic            UNITY_BYPASS_CLOSE,
    output logic            LEFT_SPEAKER_OUTPUT_TIE,
    output logic            RIGHT_SPEAKER_OUTPUT_TIE,
    output logic            AUX_OUTPUT_FIRST_TIE,
    output logic            AUX_OUTPUT_SECOND_TIE,
    output logic            LEFT_HEADPHONE_OUTPUT_TIE,
    output logic            RIGHT_HEADPHONE_OUTPUT_TIE,
    // mode and interrupt
    output logic            FOUR_WIRE_MODE,
    output logic            IRQ
);
    typedef struct packed {
        logic [8:0] override_v;
        logic [8:0] key_first;
        logic [8:0] key_second;
        logic [8:0] key_third;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic [2:0] mute_prev;
        logic       mode_prev;
        logic [8:0] rdata;
        tieoff_pkg::switch_s sw;
        logic       four_wire;
        logic       irq;
    } st_s;

    st_s st_reg;
    st_s st_next;

    logic [2:0]          mute_sync;
    logic [2:0]          mute_raw;
    tieoff_pkg::mute_s   mute;
    tieoff_pkg::switch_s ovr_sw;
    tieoff_pkg::switch_s auto_sw;
    tieoff_pkg::switch_s sel_sw;
    tieoff_pkg::bus_req_s req;

    assign mute_raw = {ANA_MUTE_IN, LEFT_ZERO_IN, RIGHT_ZERO_IN};
    assign req      = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

    tieoff_sync #(
        .W(3)
    ) u_sync (
        .clk (REF_CLK),
        .nrst(NRST),
        .d   (mute_raw),
        .q   (mute_sync)
    );

    assign mute = tieoff_pkg::mute_s'(mute_sync);

    // override bits below the enable
    assign ovr_sw  = tieoff_pkg::switch_s'(st_reg.override_v[7:0]);
    assign auto_sw = tieoff_pkg::switch_s'(AUTO_SWITCH);

    tieoff_switch_mux u_mux (
        .ovr_en(st_reg.override_v[tieoff_pkg::BIT_OVR_EN]),
        .ovr   (ovr_sw),
        .autosw(auto_sw),
        .sel   (sel_sw)
    );

    function automatic logic keys_ok(input logic [8:0] a, input logic [8:0] b,
                                     input logic [8:0] c);
        keys_ok = (a == tieoff_pkg::KEY_FIRST) && (b == tieoff_pkg::KEY_SECOND)
                  && (c == tieoff_pkg::KEY_THIRD);
    endfunction

    logic [3:0] evt;
    logic [3:0] clr;
    logic [8:0] rd_mux;

    always_comb begin
        st_next = st_reg;
        evt     = '0;
        clr     = '0;
        rd_mux  = '0;
        // register writes
        if (req.wr) begin
            if (req.addr == tieoff_pkg::OFS_OVERRIDE) begin
                st_next.override_v = req.wdata;
            end else if (req.addr == tieoff_pkg::OFS_KEY_FIRST) begin
                st_next.key_first = req.wdata;
            end else if (req.addr == tieoff_pkg::OFS_KEY_SECOND) begin
                st_next.key_second = req.wdata;
            end else if (req.addr == tieoff_pkg::OFS_KEY_THIRD) begin
                st_next.key_third = req.wdata;
            end else if (req.addr == tieoff_pkg::OFS_IRQ_STATUS) begin
                clr = req.wdata[3:0];
            end else if (req.addr == tieoff_pkg::OFS_IRQ_MASK) begin
                st_next.irq_mask = req.wdata[3:0];
            end
        end
        // read data, next cycle only
        if (req.rd) begin
            if (req.addr == tieoff_pkg::OFS_MUTE_STATUS) begin
                rd_mux[tieoff_pkg::BIT_ANA_MUTE]   = mute.ana_mute;
                rd_mux[tieoff_pkg::BIT_LEFT_ZERO]  = mute.left_zero;
                rd_mux[tieoff_pkg::BIT_RIGHT_ZERO] = mute.right_zero;
            end else if (req.addr == tieoff_pkg::OFS_OVERRIDE) begin
                rd_mux = st_reg.override_v;
            end else if (req.addr == tieoff_pkg::OFS_KEY_FIRST) begin
                rd_mux = st_reg.key_first;
            end else if (req.addr == tieoff_pkg::OFS_KEY_SECOND) begin
                rd_mux = st_reg.key_second;
            end else if (req.addr == tieoff_pkg::OFS_KEY_THIRD) begin
                rd_mux = st_reg.key_third;
            end else if (req.addr == tieoff_pkg::OFS_IRQ_STATUS) begin
                rd_mux = {5'h00, st_reg.irq_status};
            end else if (req.addr == tieoff_pkg::OFS_IRQ_MASK) begin
                rd_mux = {5'h00, st_reg.irq_mask};
            end
        end
        st_next.rdata = rd_mux;
        // mode key compare
        st_next.four_wire = keys_ok(st_next.key_first, st_next.key_second,
                                    st_next.key_third);
        // events on any change of status or mode
        st_next.mute_prev = mute_sync;
        st_next.mode_prev = st_reg.four_wire;
        evt[tieoff_pkg::EVT_ANA_MUTE]   = mute_sync[2] ^ st_reg.mute_prev[2];
        evt[tieoff_pkg::EVT_LEFT_ZERO]  = mute_sync[1] ^ st_reg.mute_prev[1];
        evt[tieoff_pkg::EVT_RIGHT_ZERO] = mute_sync[0] ^ st_reg.mute_prev[0];
        evt[tieoff_pkg::EVT_MODE]       = st_reg.four_wire ^ st_reg.mode_prev;
        // set wins over clear
        st_next.irq_status = (st_reg.irq_status & ~clr) | evt;
        st_next.irq        = |(st_next.irq_status & st_next.irq_mask);
        // switch outputs; bypass closes only while its buffer is off
        st_next.sw              = sel_sw;
        st_next.sw.boost_bypass = sel_sw.boost_bypass & ~BOOST_BUF_EN;
        st_next.sw.unity_bypass = sel_sw.unity_bypass & ~UNITY_BUF_EN;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA                      = st_reg.rdata;
    assign BOOST_BYPASS_CLOSE         = st_reg.sw.boost_bypass;
    assign UNITY_BYPASS_CLOSE         = st_reg.sw.unity_bypass;
    assign LEFT_SPEAKER_OUTPUT_TIE    = st_reg.sw.spk_left;
    assign RIGHT_SPEAKER_OUTPUT_TIE   = st_reg.sw.spk_right;
    assign AUX_OUTPUT_FIRST_TIE       = st_reg.sw.aux_first;
    assign AUX_OUTPUT_SECOND_TIE      = st_reg.sw.aux_second;
    assign LEFT_HEADPHONE_OUTPUT_TIE  = st_reg.sw.hp_left;
    assign RIGHT_HEADPHONE_OUTPUT_TIE = st_reg.sw.hp_right;
    assign FOUR_WIRE_MODE             = st_reg.four_wire;
    assign IRQ                        = st_reg.irq;

    // automatic path when override is off
    ovr_off_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !st_reg.override_v[8] && $stable(st_reg.override_v) ##1 1
        |-> {LEFT_SPEAKER_OUTPUT_TIE, RIGHT_SPEAKER_OUTPUT_TIE, AUX_OUTPUT_FIRST_TIE,
        AUX_OUTPUT_SECOND_TIE, LEFT_HEADPHONE_OUTPUT_TIE, RIGHT_HEADPHONE_OUTPUT_TIE}
        == $past(AUTO_SWITCH[5:0]))
        else $error("override off did not follow automatic");
    boost_bypass_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_reg.override_v[8] && st_reg.override_v[7] && !BOOST_BUF_EN
        |=> BOOST_BYPASS_CLOSE)
        else $error("boost bypass not closed");
    unity_bypass_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        UNITY_BUF_EN |=> !UNITY_BYPASS_CLOSE)
        else $error("unity bypass closed while buffer on");
    speaker_force_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_reg.override_v[8] |=> LEFT_SPEAKER_OUTPUT_TIE == $past(st_reg.override_v[5])
        && RIGHT_SPEAKER_OUTPUT_TIE == $past(st_reg.override_v[4]))
        else $error("speaker tie-off not forced");
    aux_force_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_reg.override_v[8] |=> AUX_OUTPUT_FIRST_TIE == $past(st_reg.override_v[3])
        && AUX_OUTPUT_SECOND_TIE == $past(st_reg.override_v[2]))
        else $error("aux tie-off not forced");
    hp_force_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_reg.override_v[8] |=> LEFT_HEADPHONE_OUTPUT_TIE == $past(st_reg.override_v[1])
        && RIGHT_HEADPHONE_OUTPUT_TIE == $past(st_reg.override_v[0]))
        else $error("headphone tie-off not forced");
    mode_key_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        FOUR_WIRE_MODE == (st_reg.key_first == tieoff_pkg::KEY_FIRST
        && st_reg.key_second == tieoff_pkg::KEY_SECOND
        && st_reg.key_third == tieoff_pkg::KEY_THIRD))
        else $error("four-wire mode disagrees with keys");
    mute_read_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == tieoff_pkg::OFS_MUTE_STATUS
        |=> RDATA == {6'h00, $past(mute_sync)})
        else $error("mute status readback wrong");
    irq_level_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        ##1 IRQ == |(st_reg.irq_status & st_reg.irq_mask))
        else $error("interrupt level wrong");

    // bypass switches against buffer state and automatic or override requests
    boost_open_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        BOOST_BUF_EN |=> !BOOST_BYPASS_CLOSE)
        else $error("boost bypass closed while buffer on");
    boost_auto_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        AUTO_SWITCH[7] && !BOOST_BUF_EN |=> BOOST_BYPASS_CLOSE)
        else $error("automatic boost bypass request dropped");
    unity_auto_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        AUTO_SWITCH[6] && !UNITY_BUF_EN |=> UNITY_BYPASS_CLOSE)
        else $error("automatic unity bypass request dropped");
    unity_close_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_reg.override_v[tieoff_pkg::BIT_OVR_EN]
        && st_reg.override_v[tieoff_pkg::BIT_BUF_UNITY]
        && !UNITY_BUF_EN |=> UNITY_BYPASS_CLOSE)
        else $error("unity bypass not closed");

    // read back paths
    zero_flag_read_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == tieoff_pkg::OFS_MUTE_STATUS
        |=> RDATA[tieoff_pkg::BIT_LEFT_ZERO] == $past(mute.left_zero)
        && RDATA[tieoff_pkg::BIT_RIGHT_ZERO] == $past(mute.right_zero))
        else $error("zero gain flag readback wrong");
    status_read_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == tieoff_pkg::OFS_IRQ_STATUS
        |=> RDATA == {5'h00, $past(st_reg.irq_status)})
        else $error("status readback wrong");
    mask_read_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == tieoff_pkg::OFS_IRQ_MASK
        |=> RDATA == {5'h00, $past(st_reg.irq_mask)})
        else $error("mask readback wrong");
    key_read_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == tieoff_pkg::OFS_KEY_FIRST
        |=> RDATA == $past(st_reg.key_first))
        else $error("first key readback wrong");
    rdata_idle_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !RD |=> RDATA == 9'h000)
        else $error("read data present without a read");

    // register writes land one cycle later
    override_store_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == tieoff_pkg::OFS_OVERRIDE
        |=> st_reg.override_v == $past(WDATA))
        else $error("override write lost");
    key_first_store_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == tieoff_pkg::OFS_KEY_FIRST
        |=> st_reg.key_first == $past(WDATA))
        else $error("first key write lost");
    key_second_store_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == tieoff_pkg::OFS_KEY_SECOND
        |=> st_reg.key_second == $past(WDATA))
        else $error("second key write lost");
    key_third_store_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == tieoff_pkg::OFS_KEY_THIRD
        |=> st_reg.key_third == $past(WDATA))
        else $error("third key write lost");
    mask_store_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == tieoff_pkg::OFS_IRQ_MASK
        |=> st_reg.irq_mask == $past(WDATA[3:0]))
        else $error("mask write lost");
    override_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !WR |=> $stable(st_reg.override_v))
        else $error("override changed without a write");
    key_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !WR |=> $stable(st_reg.key_first) && $stable(st_reg.key_second)
        && $stable(st_reg.key_third))
        else $error("key changed without a write");

    // event bits: set beats a clear in the same cycle
    set_wins_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        evt != 4'h0 |=> (st_reg.irq_status & $past(evt)) == $past(evt))
        else $error("status event lost");
    w1c_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == tieoff_pkg::OFS_IRQ_STATUS
        |=> (st_reg.irq_status & $past(WDATA[3:0] & ~evt)) == 4'h0)
        else $error("status bit not cleared by write of one");
    mode_event_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        $changed(FOUR_WIRE_MODE) |=> st_reg.irq_status[tieoff_pkg::EVT_MODE])
        else $error("mode change did not set its status bit");
endmodule // tieoff_regs
`default_nettype wire

// [design/tieoff_pkg.sv]
// package of register map, field positions and key values for the tie-off bank
`default_nettype none
package tieoff_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 9;
    // printed register offsets
    localparam logic [7:0] OFS_MUTE_STATUS = 8'h4e;
    localparam logic [7:0] OFS_OVERRIDE    = 8'h4f;
    localparam logic [7:0] OFS_KEY_FIRST   = 8'h57;
    localparam logic [7:0] OFS_KEY_SECOND  = 8'h6c;
    localparam logic [7:0] OFS_KEY_THIRD   = 8'h73;
    // own registers: event status and mask
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h80;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h81;
    // mute status bit positions
    localparam int BIT_ANA_MUTE   = 2;
    localparam int BIT_LEFT_ZERO  = 1;
    localparam int BIT_RIGHT_ZERO = 0;
    // override bit positions
    localparam int BIT_OVR_EN     = 8;
    localparam int BIT_BUF_BOOST  = 7;
    localparam int BIT_BUF_UNITY  = 6;
    localparam int BIT_SPK_LEFT   = 5;
    localparam int BIT_SPK_RIGHT  = 4;
    localparam int BIT_AUX_FIRST  = 3;
    localparam int BIT_AUX_SECOND = 2;
    localparam int BIT_HP_LEFT    = 1;
    localparam int BIT_HP_RIGHT   = 0;
    // event bit positions
    localparam int EVT_W          = 4;
    localparam int EVT_ANA_MUTE   = 0;
    localparam int EVT_LEFT_ZERO  = 1;
    localparam int EVT_RIGHT_ZERO = 2;
    localparam int EVT_MODE       = 3;
    // reset values and keys
    localparam logic [8:0] RESET_VALUE = 9'h000;
    localparam logic [8:0] KEY_FIRST   = 9'h115;
    localparam logic [8:0] KEY_SECOND  = 9'h03b;
    localparam logic [8:0] KEY_THIRD   = 9'h129;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [8:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic boost_bypass;
        logic unity_bypass;
        logic spk_left;
        logic spk_right;
        logic aux_first;
        logic aux_second;
        logic hp_left;
        logic hp_right;
    } switch_s;

    typedef struct packed {
        logic ana_mute;
        logic left_zero;
        logic right_zero;
    } mute_s;
endpackage
`default_nettype wire

// [design/tieoff_sync.sv]
// two-flop synchroniser for the mute status inputs
`default_nettype none
module tieoff_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } st_s;
    st_s st_reg;
    st_s st_next;
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign q = st_reg.s2;
endmodule // tieoff_sync
`default_nettype wire

// [design/tieoff_switch_mux.sv]
// selects automatic or overridden output ties; with override on, the bypass requests are the OR of both
`default_nettype none
module tieoff_switch_mux (
    // control
    input  wire logic               ovr_en,
    input  wire tieoff_pkg::switch_s ovr,
    input  wire tieoff_pkg::switch_s autosw,
    // result
    output tieoff_pkg::switch_s      sel
);
    tieoff_pkg::switch_s m;
    always_comb begin
        m = autosw;
        if (ovr_en) begin
            m.boost_bypass = ovr.boost_bypass | autosw.boost_bypass;
            m.unity_bypass = ovr.unity_bypass | autosw.unity_bypass;
            m.spk_left     = ovr.spk_left;
            m.spk_right    = ovr.spk_right;
            m.aux_first    = ovr.aux_first;
            m.aux_second   = ovr.aux_second;
            m.hp_left      = ovr.hp_left;
            m.hp_right     = ovr.hp_right;
        end
    end
    assign sel = m;
endmodule // tieoff_switch_mux
`default_nettype wire

// [testbench/host_model.sv]
// host model driving the register port of the tie-off bank
`default_nettype none
module host_model (
    // clock
    input  wire logic       clk,
    // register port
    output logic      [7:0] addr,
    output logic      [8:0] wdata,
    output logic            wr,
    output logic            rd,
    input  wire logic [8:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr  = 8'h00;
        wdata = 9'h000;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    // one-cycle write, then released lines show inverted values
    task automatic write_reg(input logic [7:0] a, input logic [8:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask
    // one-cycle read, data taken in the cycle after
    task automatic read_reg(input logic [7:0] a, output logic [8:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule // host_model
`default_nettype wire

// [testbench/test_tieoff_regs.sv]
// self-checking bench for the tie-off, mute status and key register bank
`default_nettype none
module test_tieoff_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic       REF_CLK = 1'b0;
    logic       NRST = 1'b0;
    logic [7:0] addr;
    logic [8:0] wdata;
    logic       wr;
    logic       rd;
    logic [8:0] rdata;
    logic [2:0] mute_in = 3'b000;
    logic [7:0] auto_sw = 8'h00;
    logic       boost_en = 1'b0;
    logic       unity_en = 1'b0;
    logic [7:0] sw;
    logic       mode;
    logic       irq;
    int         n_mismatch = 0;
    int         compares = 0;
    always #2 REF_CLK = ~REF_CLK;
    host_model HOST (.clk(REF_CLK), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    tieoff_regs DUT (
        .REF_CLK(REF_CLK), .NRST(NRST), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ANA_MUTE_IN(mute_in[2]), .LEFT_ZERO_IN(mute_in[1]),
        .RIGHT_ZERO_IN(mute_in[0]), .AUTO_SWITCH(auto_sw), .BOOST_BUF_EN(boost_en),
        .UNITY_BUF_EN(unity_en), .BOOST_BYPASS_CLOSE(sw[7]), .UNITY_BYPASS_CLOSE(sw[6]),
        .LEFT_SPEAKER_OUTPUT_TIE(sw[5]), .RIGHT_SPEAKER_OUTPUT_TIE(sw[4]),
        .AUX_OUTPUT_FIRST_TIE(sw[3]), .AUX_OUTPUT_SECOND_TIE(sw[2]),
        .LEFT_HEADPHONE_OUTPUT_TIE(sw[1]), .RIGHT_HEADPHONE_OUTPUT_TIE(sw[0]),
        .FOUR_WIRE_MODE(mode), .IRQ(irq));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [8:0] exp);
        logic [8:0] d;
        HOST.read_reg(a, d);
        chk(d, exp);
    endtask
    // lets a write reach the registered outputs
    task automatic settle();
        repeat (2) @(posedge REF_CLK);
        #1;
    endtask
    task automatic t_reset();
        chk({sw, mode}, 9'h000);
        chk({8'h00, irq}, 9'h000);
        rd_chk(tieoff_pkg::OFS_OVERRIDE, tieoff_pkg::RESET_VALUE);
        rd_chk(tieoff_pkg::OFS_KEY_FIRST, tieoff_pkg::RESET_VALUE);
        rd_chk(tieoff_pkg::OFS_KEY_SECOND, tieoff_pkg::RESET_VALUE);
        rd_chk(tieoff_pkg::OFS_KEY_THIRD, tieoff_pkg::RESET_VALUE);
        rd_chk(tieoff_pkg::OFS_IRQ_MASK, 9'h000);
        rd_chk(tieoff_pkg::OFS_IRQ_STATUS, 9'h000);
        HOST.write_reg(tieoff_pkg::OFS_MUTE_STATUS, 9'h1ff);
        rd_chk(tieoff_pkg::OFS_MUTE_STATUS, 9'h000);
        HOST.write_reg(8'h10, 9'h1ff);
        rd_chk(8'h10, 9'h000);
    endtask
    task automatic t_override();
        @(posedge REF_CLK);
        auto_sw <= 8'ha5;
        HOST.write_reg(tieoff_pkg::OFS_OVERRIDE, 9'h0ff);
        settle();
        chk({1'b0, sw}, 9'h0a5);
        HOST.write_reg(tieoff_pkg::OFS_OVERRIDE, 9'h100);
        settle();
        chk({1'b0, sw}, 9'h080);
        @(posedge REF_CLK);
        auto_sw <= 8'h00;
        for (int i = 0; i < 8; i++) begin
            HOST.write_reg(tieoff_pkg::OFS_OVERRIDE, 9'h100 | (9'h001 << i));
            settle();
            chk({1'b0, sw}, 9'h001 << i);
        end
        @(posedge REF_CLK);
        boost_en <= 1'b1;
        unity_en <= 1'b1;
        HOST.write_reg(tieoff_pkg::OFS_OVERRIDE, 9'h1ff);
        settle();
        chk({1'b0, sw}, 9'h03f);
        rd_chk(tieoff_pkg::OFS_OVERRIDE, 9'h1ff);
        @(posedge REF_CLK);
        boost_en <= 1'b0;
        unity_en <= 1'b0;
        HOST.write_reg(tieoff_pkg::OFS_OVERRIDE, 9'h000);
    endtask
    task automatic t_mute();
        for (int i = 0; i < 3; i++) begin
            mute_in <= 3'b100 >> i;
            repeat (6) @(posedge REF_CLK);
            rd_chk(tieoff_pkg::OFS_MUTE_STATUS, 9'h004 >> i);
            rd_chk(tieoff_pkg::OFS_IRQ_STATUS, 9'h001 << i);
            chk({8'h00, irq}, 9'h000);
            HOST.write_reg(tieoff_pkg::OFS_IRQ_MASK, 9'h001 << i);
            settle();
            chk({8'h00, irq}, 9'h001);
            HOST.write_reg(tieoff_pkg::OFS_IRQ_STATUS, 9'h001 << i);
            settle();
            chk({8'h00, irq}, 9'h000);
            rd_chk(tieoff_pkg::OFS_IRQ_STATUS, 9'h000);
            HOST.write_reg(tieoff_pkg::OFS_IRQ_MASK, 9'h000);
            mute_in <= 3'b000;
            repeat (6) @(posedge REF_CLK);
            HOST.write_reg(tieoff_pkg::OFS_IRQ_STATUS, 9'h00f);
        end
    endtask
    task automatic t_keys();
        HOST.write_reg(tieoff_pkg::OFS_KEY_FIRST, 9'h115);
        HOST.write_reg(tieoff_pkg::OFS_KEY_SECOND, 9'h03b);
        HOST.write_reg(tieoff_pkg::OFS_KEY_THIRD, 9'h128);
        settle();
        chk({8'h00, mode}, 9'h000);
        HOST.write_reg(tieoff_pkg::OFS_KEY_THIRD, 9'h129);
        settle();
        chk({8'h00, mode}, 9'h001);
        rd_chk(tieoff_pkg::OFS_KEY_FIRST, 9'h115);
        rd_chk(tieoff_pkg::OFS_KEY_SECOND, 9'h03b);
        rd_chk(tieoff_pkg::OFS_KEY_THIRD, 9'h129);
        rd_chk(tieoff_pkg::OFS_IRQ_STATUS, 9'h008);
        HOST.write_reg(tieoff_pkg::OFS_KEY_FIRST, 9'h114);
        settle();
        chk({8'h00, mode}, 9'h000);
    endtask
    // a clear that meets its event in one cycle leaves the bit set
    task automatic t_set_wins();
        mute_in <= 3'b100;
        @(posedge REF_CLK);
        HOST.write_reg(tieoff_pkg::OFS_IRQ_STATUS, 9'h001);
        rd_chk(tieoff_pkg::OFS_IRQ_STATUS, 9'h001);
        @(posedge REF_CLK);
        mute_in <= 3'b000;
        repeat (6) @(posedge REF_CLK);
        HOST.write_reg(tieoff_pkg::OFS_IRQ_STATUS, 9'h00f);
        rd_chk(tieoff_pkg::OFS_IRQ_STATUS, 9'h000);
    endtask
    // second reset in mid-run returns every register to zero
    task automatic t_rerun();
        HOST.write_reg(tieoff_pkg::OFS_OVERRIDE, 9'h1ff);
        HOST.write_reg(tieoff_pkg::OFS_IRQ_MASK, 9'h00f);
        settle();
        chk({8'h00, irq}, 9'h001);
        @(posedge REF_CLK);
        NRST <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        NRST <= 1'b1;
        t_reset();
    endtask
    task automatic complete_run();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge REF_CLK);
        NRST <= 1'b1;
        t_reset();
        t_override();
        t_mute();
        t_set_wins();
        t_keys();
        t_rerun();
        complete_run();
    end
endmodule // test_tieoff_regs
`default_nettype wire
